/* shared/hps_regs.svh */
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH

// Register byte offsets
`define HPS_OFF_PCTL   8'h00
`define HPS_OFF_DDR    8'h04
`define HPS_OFF_GDAT   8'h08
`define HPS_OFF_STAT   8'h0C

// Port control field positions
`define HPS_PCTL_HOST  0
`define HPS_PCTL_DSTRB 1
`define HPS_PCTL_DREQ  2
`define HPS_PCTL_DSPOL 3
`define HPS_PCTL_RQPOL 4
`define HPS_PCTL_AKPOL 5
`define HPS_PCTL_ROD   6

// Pin slots
`define HPS_PIN_B11    0
`define HPS_PIN_B12    1
`define HPS_PIN_B14    2
`define HPS_PIN_B15    3

// Reset values
`define HPS_PCTL_RST   16'h0000
`define HPS_DDR_RST    4'h0
`define HPS_GDAT_RST   4'h0

`endif

/* shared/hps_pkg.sv */
package hps_pkg;

   typedef enum logic [1:0] {
      HPS_RESP_OKAY   = 2'h0,
      HPS_RESP_SLVERR = 2'h2
   } hps_resp_t;

   typedef logic [3:0] hps_pins_t;

endpackage : hps_pkg

/* hw/hps_pins.sv */
// Operation
// - Single strobe: direction pin selects read/write
// - Single data strobe, programmable polarity, low default
// - Double strobe: read strobe, polarity, low default
// - Double strobe: write strobe, polarity, low default
// - Single request: combined request out, low default
// - Single request: acknowledge input, low default
// - Double request: transmit request out, low default
// - Double request: receive request out, low default
// - Request outputs driven or open-drain
// - GPIO mode: bits 11,12,14,15 per-bit direction
// - Stop: inputs ignored
// - Stop: outputs keep last level
// - Wait state changes nothing on pins
// - Sixteen-bit port control selects functions
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hps_regs.svh"

module hps_pins
   import hps_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_rst_b,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   // Power state
   input  wire logic              i_stop,
   // Pins 11, 12, 14, 15
   input  wire hps_pins_t         i_pin,
   output hps_pins_t              o_pin,
   output hps_pins_t              o_pin_oe_b,
   // Internal host side
   input  wire logic              i_host_transmit_request,
   input  wire logic              i_host_receive_request,
   output logic                   o_host_read_strobe,
   output logic                   o_host_write_strobe,
   output logic                   o_host_read_write_sel,
   output logic                   o_host_acknowledge_in
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and synchroniser state
   logic [15:0] pctl_reg;
   hps_pins_t   ddr_reg;
   hps_pins_t   gdat_reg;
   hps_pins_t   sync1_reg;
   hps_pins_t   sync2_reg;
   hps_pins_t   sync3_reg;
   hps_pins_t   flt_reg;
   hps_pins_t   pin_next;
   hps_pins_t   oe_b_next;
   logic        host_sel;
   logic        dstrb;
   logic        dreq;
   logic        ds_pol;
   logic        rq_pol;
   logic        ak_pol;
   logic        rq_od;
   logic        req_comb;
   logic        aw_ok;
   logic        ar_ok;
   logic        do_write;

   // Fields of port control
   assign host_sel = pctl_reg[`HPS_PCTL_HOST];
   assign dstrb    = pctl_reg[`HPS_PCTL_DSTRB];
   assign dreq     = pctl_reg[`HPS_PCTL_DREQ];
   assign ds_pol   = pctl_reg[`HPS_PCTL_DSPOL];
   assign rq_pol   = pctl_reg[`HPS_PCTL_RQPOL];
   assign ak_pol   = pctl_reg[`HPS_PCTL_AKPOL];
   assign rq_od    = pctl_reg[`HPS_PCTL_ROD];

   ////////////////////////////////////////////////////////////////////////////
   // Three-stage input synchronisers
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge i_mclk) begin
            if (!i_rst_b) begin
               sync1_reg[gi] <= 1'h0;
               sync2_reg[gi] <= 1'h0;
               sync3_reg[gi] <= 1'h0;
               flt_reg[gi]   <= 1'h0;
            end else begin
               sync1_reg[gi] <= i_pin[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
               if (!i_stop && sync2_reg[gi] == sync3_reg[gi]) begin
                  flt_reg[gi] <= sync3_reg[gi];
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Active-high decode of strobes and acknowledge
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_host_read_strobe    <= 1'h0;
         o_host_write_strobe   <= 1'h0;
         o_host_read_write_sel <= 1'h0;
         o_host_acknowledge_in <= 1'h0;
      end else if (!host_sel) begin
         o_host_read_strobe    <= 1'h0;
         o_host_write_strobe   <= 1'h0;
         o_host_read_write_sel <= 1'h0;
         o_host_acknowledge_in <= 1'h0;
      end else if (!dstrb) begin
         o_host_read_write_sel <= flt_reg[`HPS_PIN_B11];
         o_host_read_strobe    <= (flt_reg[`HPS_PIN_B12] ~^ ds_pol) & flt_reg[`HPS_PIN_B11];
         o_host_write_strobe   <= (flt_reg[`HPS_PIN_B12] ~^ ds_pol) & ~flt_reg[`HPS_PIN_B11];
         o_host_acknowledge_in <= !dreq && (flt_reg[`HPS_PIN_B15] ~^ ak_pol);
      end else begin
         o_host_read_write_sel <= 1'h0;
         o_host_read_strobe    <= flt_reg[`HPS_PIN_B11] ~^ ds_pol;
         o_host_write_strobe   <= flt_reg[`HPS_PIN_B12] ~^ ds_pol;
         o_host_acknowledge_in <= !dreq && (flt_reg[`HPS_PIN_B15] ~^ ak_pol);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive selection
   assign req_comb = i_host_transmit_request | i_host_receive_request;

   always_comb begin
      pin_next  = gdat_reg;
      oe_b_next = ~ddr_reg;
      if (host_sel) begin
         pin_next  = 4'h0;
         oe_b_next = 4'hF;
         if (rq_od) begin
            pin_next[`HPS_PIN_B14]  = rq_pol;
            oe_b_next[`HPS_PIN_B14] = ~(dreq ? i_host_transmit_request : req_comb);
         end else begin
            pin_next[`HPS_PIN_B14]  = (dreq ? i_host_transmit_request : req_comb) ~^ rq_pol;
            oe_b_next[`HPS_PIN_B14] = 1'h0;
         end
         if (dreq && rq_od) begin
            pin_next[`HPS_PIN_B15]  = rq_pol;
            oe_b_next[`HPS_PIN_B15] = ~i_host_receive_request;
         end else if (dreq) begin
            pin_next[`HPS_PIN_B15]  = i_host_receive_request ~^ rq_pol;
            oe_b_next[`HPS_PIN_B15] = 1'h0;
         end
      end
   end

   // Stop freezes the pins; wait is not an input here at all
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_pin      <= 4'h0;
         o_pin_oe_b <= 4'hF;
      end else if (!i_stop) begin
         o_pin      <= pin_next;
         o_pin_oe_b <= oe_b_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   assign aw_ok    = (i_awaddr == ADDR_W'(`HPS_OFF_PCTL)) || (i_awaddr == ADDR_W'(`HPS_OFF_DDR))
                     || (i_awaddr == ADDR_W'(`HPS_OFF_GDAT)) || (i_awaddr == ADDR_W'(`HPS_OFF_STAT));
   assign do_write = !o_awready && !o_wready && !o_bvalid;

   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              aw_ok_reg;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_awready  <= 1'h1;
         o_wready   <= 1'h1;
         o_bvalid   <= 1'h0;
         o_bresp    <= HPS_RESP_OKAY;
         awaddr_reg <= '0;
         aw_ok_reg  <= 1'h0;
         wdata_reg  <= 32'h0;
         wstrb_reg  <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            o_awready  <= 1'h0;
            awaddr_reg <= i_awaddr;
            aw_ok_reg  <= aw_ok;
         end
         if (i_wvalid && o_wready) begin
            o_wready  <= 1'h0;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
         end
         if (do_write) begin
            o_bvalid <= 1'h1;
            o_bresp  <= aw_ok_reg ? HPS_RESP_OKAY : HPS_RESP_SLVERR;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'h0;
            o_awready <= 1'h1;
            o_wready  <= 1'h1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         pctl_reg <= `HPS_PCTL_RST;
         ddr_reg  <= `HPS_DDR_RST;
         gdat_reg <= `HPS_GDAT_RST;
      end else if (do_write) begin
         if (awaddr_reg == ADDR_W'(`HPS_OFF_PCTL)) begin
            if (wstrb_reg[0]) pctl_reg[7:0]  <= wdata_reg[7:0];
            if (wstrb_reg[1]) pctl_reg[15:8] <= wdata_reg[15:8];
         end
         if (awaddr_reg == ADDR_W'(`HPS_OFF_DDR) && wstrb_reg[0]) begin
            ddr_reg <= wdata_reg[3:0];
         end
         if (awaddr_reg == ADDR_W'(`HPS_OFF_GDAT) && wstrb_reg[0]) begin
            gdat_reg <= wdata_reg[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   assign ar_ok = (i_araddr == ADDR_W'(`HPS_OFF_PCTL)) || (i_araddr == ADDR_W'(`HPS_OFF_DDR))
                  || (i_araddr == ADDR_W'(`HPS_OFF_GDAT)) || (i_araddr == ADDR_W'(`HPS_OFF_STAT));

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_arready <= 1'h1;
         o_rvalid  <= 1'h0;
         o_rdata   <= 32'h0;
         o_rresp   <= HPS_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'h0;
         o_rvalid  <= 1'h1;
         o_rresp   <= ar_ok ? HPS_RESP_OKAY : HPS_RESP_SLVERR;
         o_rdata   <= 32'h0;
         if (i_araddr == ADDR_W'(`HPS_OFF_PCTL)) o_rdata[15:0] <= pctl_reg;
         if (i_araddr == ADDR_W'(`HPS_OFF_DDR))  o_rdata[3:0]  <= ddr_reg;
         if (i_araddr == ADDR_W'(`HPS_OFF_GDAT)) o_rdata[3:0]  <= gdat_reg;
         if (i_araddr == ADDR_W'(`HPS_OFF_STAT)) begin
            o_rdata[7:0] <= {o_host_acknowledge_in, o_host_read_write_sel,
                             o_host_write_strobe, o_host_read_strobe, flt_reg};
         end
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'h0;
         o_arready <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   AST_RW_SEL: assert property (
      $past(host_sel && !dstrb) && $past(i_rst_b) |-> o_host_read_write_sel == $past(flt_reg[`HPS_PIN_B11]))
      else $error("read/write select does not follow pin");

   AST_SINGLE_STRB: assert property (
      $past(host_sel && !dstrb) && $past(i_rst_b)
      |-> o_host_read_strobe == $past((flt_reg[`HPS_PIN_B12] ~^ ds_pol) & flt_reg[`HPS_PIN_B11]))
      else $error("single strobe read decode wrong");

   AST_READ_STRB: assert property (
      $past(host_sel && dstrb) && $past(i_rst_b) |-> o_host_read_strobe == $past(flt_reg[`HPS_PIN_B11] ~^ ds_pol))
      else $error("read strobe decode wrong");

   AST_WRITE_STRB: assert property (
      $past(host_sel && dstrb) && $past(i_rst_b) |-> o_host_write_strobe == $past(flt_reg[`HPS_PIN_B12] ~^ ds_pol))
      else $error("write strobe decode wrong");

   AST_COMB_REQ: assert property (
      !i_stop && host_sel && !dreq && !rq_od ##1 !i_stop
      |-> o_pin[`HPS_PIN_B14] == ($past(req_comb) ~^ $past(rq_pol)) && !o_pin_oe_b[`HPS_PIN_B14])
      else $error("combined request level wrong");

   AST_ACK: assert property (
      $past(host_sel && !dreq) && $past(i_rst_b) |-> o_host_acknowledge_in == $past(flt_reg[`HPS_PIN_B15] ~^ ak_pol))
      else $error("acknowledge decode wrong");

   AST_RX_REQ: assert property (
      !i_stop && host_sel && dreq && !rq_od
      |=> o_pin[`HPS_PIN_B15] == ($past(i_host_receive_request) ~^ $past(rq_pol)))
      else $error("receive request level wrong");

   AST_TX_REQ: assert property (
      !i_stop && host_sel && dreq && !rq_od
      |=> o_pin[`HPS_PIN_B14] == ($past(i_host_transmit_request) ~^ $past(rq_pol)))
      else $error("transmit request level wrong");

   AST_OPEN_DRAIN: assert property (
      !i_stop && host_sel && rq_od |=> o_pin[`HPS_PIN_B14] == $past(rq_pol)
      && o_pin_oe_b[`HPS_PIN_B14] == !$past(dreq ? i_host_transmit_request : req_comb))
      else $error("open-drain request wrong");

   AST_GPIO_DIR: assert property (
      !i_stop && !host_sel |=> o_pin_oe_b == ~$past(ddr_reg) && o_pin == $past(gdat_reg))
      else $error("gpio direction wrong");

   AST_STOP_IN: assert property (
      i_stop |=> $stable(flt_reg))
      else $error("input sampled in stop");

   AST_STOP_OUT: assert property (
      i_stop ##1 i_stop |-> $stable(o_pin) && $stable(o_pin_oe_b))
      else $error("output changed in stop");

endmodule : hps_pins
`default_nettype wire

/* verif/hps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module hps_host_model
   import hps_pkg::*;
(
   // Device side of the four pins
   input  wire hps_pins_t i_pin_out,
   input  wire hps_pins_t i_pin_oe_b,
   // Host drive per pin
   input  wire hps_pins_t i_host_en,
   input  wire hps_pins_t i_host_drv,
   // Resolved wire level
   output hps_pins_t      o_pin_lvl
);
   ////////////////////////////////////////////////////////////////////////////
   // Device drive wins, then host, else board pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         o_pin_lvl[i] = !i_pin_oe_b[i] ? i_pin_out[i] : (i_host_en[i] ? i_host_drv[i] : 1'b1);
      end
   end
endmodule : hps_host_model

`default_nettype wire

/* verif/test_hps_pins.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hps_regs.svh"

module test_hps_pins
   import hps_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_b, stop, awvalid, wvalid, bready, arvalid, rready, tx_req, rx_req;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, host_en, host_drv, pin_lvl, pin_out, pin_oe_b;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, rd_stb, wr_stb, rw_sel, ack_in;
   int          n_mismatch = 0;
   int          n_tests = 0;

   always #12.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Design and host
   hps_pins dut_u (
      .i_mclk(clk), .i_rst_b(rst_b),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_stop(stop), .i_pin(pin_lvl), .o_pin(pin_out), .o_pin_oe_b(pin_oe_b),
      .i_host_transmit_request(tx_req), .i_host_receive_request(rx_req),
      .o_host_read_strobe(rd_stb), .o_host_write_strobe(wr_stb),
      .o_host_read_write_sel(rw_sel), .o_host_acknowledge_in(ack_in)
   );

   hps_host_model host_u (
      .i_pin_out(pin_out), .i_pin_oe_b(pin_oe_b),
      .i_host_en(host_en), .i_host_drv(host_drv), .o_pin_lvl(pin_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic complete_run;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Read or write; d is write data or expected read data
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int          n;
      logic        ta, tw, tk, dn;
      logic [1:0]  rs;
      logic [31:0] rv;
      n = 0;
      dn = 1'b0;
      rs = 2'h3;
      rv = 32'h0;
      @(posedge clk);
      if (w) begin
         awaddr <= a;
         awvalid <= 1'b1;
         wdata <= d;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      while (!dn && n < 50) begin
         @(negedge clk);
         ta = w ? (awvalid && awready) : (arvalid && arready);
         tw = wvalid && wready;
         tk = (bready && bvalid) || (rready && rvalid);
         rs = w ? bresp : rresp;
         rv = rdata;
         @(posedge clk);
         if (ta) begin
            awvalid <= 1'b0;
            arvalid <= 1'b0;
         end
         if (tw) wvalid <= 1'b0;
         if (tk) begin
            bready <= 1'b0;
            rready <= 1'b0;
            dn = 1'b1;
         end
         n++;
      end
      if (!dn) chk("axi_done", 32'h1, 32'h0);
      chk("resp", {30'h0, er}, {30'h0, rs});
      if (!w) chk("rdata", d, rv);
   endtask : axi

   // Host pin drive, then let the input filter settle
   task automatic hostp(input logic [3:0] e, input logic [3:0] d);
      @(posedge clk);
      host_en <= e;
      host_drv <= d;
      repeat (8) @(posedge clk);
   endtask : hostp

   task automatic req(input logic t, input logic r);
      @(posedge clk);
      tx_req <= t;
      rx_req <= r;
      repeat (3) @(posedge clk);
   endtask : req

   ////////////////////////////////////////////////////////////////////////////
   // Sequence
   initial begin
      rst_b = 1'b0;
      {stop, awvalid, wvalid, bready, arvalid, rready, tx_req, rx_req} = 8'h00;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
      host_en = 4'h0;
      host_drv = 4'h0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      axi(0, `HPS_OFF_PCTL, 32'h0, HPS_RESP_OKAY);
      axi(0, `HPS_OFF_DDR, 32'h0, HPS_RESP_OKAY);
      chk("oe_b", 32'hF, pin_oe_b);
      axi(1, 8'h10, 32'h5, HPS_RESP_SLVERR);
      axi(0, 8'h10, 32'h0, HPS_RESP_SLVERR);
      axi(1, `HPS_OFF_DDR, 32'h5, HPS_RESP_OKAY);
      axi(1, `HPS_OFF_GDAT, 32'hF, HPS_RESP_OKAY);
      hostp(4'hA, 4'h2);
      chk("oe_b", 32'hA, pin_oe_b);
      chk("pins", 32'h7, pin_lvl);
      axi(0, `HPS_OFF_STAT, 32'h7, HPS_RESP_OKAY);
      @(posedge clk);
      stop <= 1'b1;
      axi(1, `HPS_OFF_GDAT, 32'h0, HPS_RESP_OKAY);
      hostp(4'hA, 4'h8);
      chk("pins", 32'hD, pin_lvl);
      chk("oe_b", 32'hA, pin_oe_b);
      axi(0, `HPS_OFF_STAT, 32'h7, HPS_RESP_OKAY);
      @(posedge clk);
      stop <= 1'b0;
      hostp(4'hA, 4'h8);
      chk("pins", 32'h8, pin_lvl);
      axi(0, `HPS_OFF_STAT, 32'h8, HPS_RESP_OKAY);
      axi(1, `HPS_OFF_PCTL, 32'h1, HPS_RESP_OKAY);
      hostp(4'hB, 4'hB);
      chk("host", 32'h4, {ack_in, rw_sel, wr_stb, rd_stb});
      chk("oe_b", 32'hB, pin_oe_b);
      chk("pins", 32'hF, pin_lvl);
      hostp(4'hB, 4'h9);
      chk("host", 32'h5, {ack_in, rw_sel, wr_stb, rd_stb});
      hostp(4'hB, 4'h8);
      chk("host", 32'h2, {ack_in, rw_sel, wr_stb, rd_stb});
      hostp(4'hB, 4'h0);
      chk("host", 32'hA, {ack_in, rw_sel, wr_stb, rd_stb});
      req(1'b0, 1'b1);
      chk("pins", 32'h0, pin_lvl);
      req(1'b0, 1'b0);
      axi(1, `HPS_OFF_PCTL, 32'h39, HPS_RESP_OKAY);
      hostp(4'hB, 4'h0);
      chk("host", 32'h0, {ack_in, rw_sel, wr_stb, rd_stb});
      chk("pins", 32'h0, pin_lvl);
      hostp(4'hB, 4'hB);
      chk("host", 32'hD, {ack_in, rw_sel, wr_stb, rd_stb});
      req(1'b1, 1'b0);
      chk("pins", 32'hF, pin_lvl);
      req(1'b0, 1'b0);
      axi(1, `HPS_OFF_PCTL, 32'h7, HPS_RESP_OKAY);
      hostp(4'h3, 4'h2);
      chk("strb", 32'h1, {wr_stb, rd_stb});
      chk("oe_b", 32'h3, pin_oe_b);
      chk("pins", 32'hE, pin_lvl);
      req(1'b0, 1'b1);
      chk("pins", 32'h6, pin_lvl);
      req(1'b0, 1'b0);
      axi(1, `HPS_OFF_PCTL, 32'hF, HPS_RESP_OKAY);
      hostp(4'h3, 4'h2);
      chk("strb", 32'h2, {wr_stb, rd_stb});
      axi(1, `HPS_OFF_PCTL, 32'h47, HPS_RESP_OKAY);
      hostp(4'h3, 4'h2);
      chk("oe_b", 32'hF, pin_oe_b);
      chk("pins", 32'hE, pin_lvl);
      req(1'b1, 1'b0);
      chk("oe_b", 32'hB, pin_oe_b);
      chk("pins", 32'hA, pin_lvl);
      complete_run();
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
endmodule : test_hps_pins

`default_nettype wire
